// File: inc/wbc_pkg.sv
// constants for the wake and bus control register bank
package wbc_pkg;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned DATA_W = 8;

    // register addresses
    localparam logic [6:0] ADDR_BUS_PEAK  = 7'h05;
    localparam logic [6:0] ADDR_INT_WAKE  = 7'h06;
    localparam logic [6:0] ADDR_EXT_WAKE  = 7'h07;

    // field positions, bus_peak_threshold_ctrl
    localparam int unsigned BIT_PEAK_TH   = 5;
    // field positions, internal_wake_source_ctrl
    localparam int unsigned BIT_TMR2_WK   = 7;
    localparam int unsigned BIT_TMR1_WK   = 6;
    localparam int unsigned BIT_WD_STOP   = 2;
    // field positions, external_wake_source_ctrl
    localparam int unsigned BIT_INT_SCOPE = 7;
    localparam int unsigned BIT_MEAS      = 5;
    localparam int unsigned BIT_IN3_WK    = 2;
    localparam int unsigned BIT_IN2_WK    = 1;
    localparam int unsigned BIT_IN1_WK    = 0;

    // implemented (non-reserved) bits of each register
    localparam logic [7:0] MASK_BUS_PEAK  = 8'h20;
    localparam logic [7:0] MASK_INT_WAKE  = 8'hc4;
    localparam logic [7:0] MASK_EXT_WAKE  = 8'ha7;

    // power-on and soft reset values
    localparam logic [7:0] RST_BUS_PEAK   = 8'h00;
    localparam logic [7:0] RST_INT_WAKE   = 8'h00;
    localparam logic [7:0] RST_EXT_WAKE   = 8'h07;

    // restart entry: bits kept, all others cleared
    localparam logic [7:0] KEEP_RS_BUS    = 8'h20;
    localparam logic [7:0] KEEP_RS_INT    = 8'hc0;
    localparam logic [7:0] KEEP_RS_EXT    = 8'ha7;

    // fail-safe entry on the external wake register
    localparam logic [7:0] KEEP_FS_EXT    = 8'ha0;
    localparam logic [7:0] SET_FS_EXT     = 8'h07;
endpackage

// File: hw/wbc_regs.sv
// wake and bus control register bank with mode-aware write gating
module wbc_regs
    import wbc_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire logic              reg_wr_valid,
    input  wire logic              reg_rd_valid,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wr_data,
    input  wire logic              mode_init,
    input  wire logic              mode_normal,
    input  wire logic              mode_stop,
    input  wire logic              soft_reset,
    input  wire logic              restart_entry,
    input  wire logic              failsafe_entry,
    input  wire logic              wd_stop_hw_valid,
    input  wire logic              wd_stop_hw_value,
    output logic [DATA_W-1:0]      reg_rd_data,
    output logic                   reg_rd_ack,
    output logic                   rail_peak_threshold_select,
    output logic                   second_timer_wake_enable,
    output logic                   first_timer_wake_enable,
    output logic                   watchdog_stop_disable_hi,
    output logic                   global_int_scope,
    output logic                   measure_mode_select,
    output logic                   input_one_wake_enable,
    output logic                   input_two_wake_enable,
    output logic                   input_three_wake_enable,
    output logic                   can_wake_force
);

    function automatic logic wr_hit(input logic v, input logic [6:0] a, input logic [6:0] t);
        wr_hit = v && (a == t);
    endfunction

    logic [7:0] bus_peak_r;
    logic [7:0] bus_peak_nxt;
    logic [7:0] int_wake_r;
    logic [7:0] int_wake_nxt;
    logic [7:0] ext_wake_r;
    logic [7:0] ext_wake_nxt;
    logic       peak_wr_ok;

    ////////////////////////////////////////////////////////////////////////////////
    // next-state: soft reset, then fail-safe (external wake register only), then restart, then writes

    // stop mode drops the write without any failure flag or interrupt
    assign peak_wr_ok = mode_init || mode_normal;

    always_comb begin
        bus_peak_nxt = bus_peak_r;
        if (soft_reset) begin
            bus_peak_nxt = RST_BUS_PEAK;
        end else if (restart_entry) begin
            bus_peak_nxt = bus_peak_r & KEEP_RS_BUS;
        end else if (wr_hit(reg_wr_valid, reg_addr, ADDR_BUS_PEAK) && peak_wr_ok) begin
            bus_peak_nxt = reg_wr_data & MASK_BUS_PEAK;
        end
    end

    always_comb begin
        int_wake_nxt = int_wake_r;
        if (soft_reset) begin
            int_wake_nxt = RST_INT_WAKE;
        end else if (restart_entry) begin
            int_wake_nxt = int_wake_r & KEEP_RS_INT;
        end else begin
            if (wr_hit(reg_wr_valid, reg_addr, ADDR_INT_WAKE)) begin
                int_wake_nxt = reg_wr_data & MASK_INT_WAKE;
            end
            // hardware update wins over a write in the same cycle
            if (wd_stop_hw_valid) begin
                int_wake_nxt[BIT_WD_STOP] = wd_stop_hw_value;
            end
        end
    end

    always_comb begin
        ext_wake_nxt = ext_wake_r;
        if (soft_reset) begin
            ext_wake_nxt = RST_EXT_WAKE;
        end else if (failsafe_entry) begin
            ext_wake_nxt = (ext_wake_r & KEEP_FS_EXT) | SET_FS_EXT;
        end else if (restart_entry) begin
            ext_wake_nxt = ext_wake_r & KEEP_RS_EXT;
        end else if (wr_hit(reg_wr_valid, reg_addr, ADDR_EXT_WAKE)) begin
            ext_wake_nxt = reg_wr_data & MASK_EXT_WAKE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // storage

    always_ff @(posedge clock) begin
        if (reset) begin
            bus_peak_r <= RST_BUS_PEAK;
            int_wake_r <= RST_INT_WAKE;
            ext_wake_r <= RST_EXT_WAKE;
        end else begin
            bus_peak_r <= bus_peak_nxt;
            int_wake_r <= int_wake_nxt;
            ext_wake_r <= ext_wake_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read port: one cycle latency, unmapped addresses read zero

    always_ff @(posedge clock) begin
        if (reset) begin
            reg_rd_data <= 8'h00;
            reg_rd_ack  <= 1'b0;
        end else begin
            reg_rd_ack <= reg_rd_valid;
            if (reg_rd_valid) begin
                unique case (reg_addr)
                    ADDR_BUS_PEAK: reg_rd_data <= bus_peak_r & MASK_BUS_PEAK;
                    ADDR_INT_WAKE: reg_rd_data <= int_wake_r & MASK_INT_WAKE;
                    ADDR_EXT_WAKE: reg_rd_data <= ext_wake_r & MASK_EXT_WAKE;
                    default:       reg_rd_data <= 8'h00;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // field outputs, registered from the next-state values so they track the bank

    always_ff @(posedge clock) begin
        if (reset) begin
            rail_peak_threshold_select <= RST_BUS_PEAK[BIT_PEAK_TH];
            second_timer_wake_enable   <= RST_INT_WAKE[BIT_TMR2_WK];
            first_timer_wake_enable    <= RST_INT_WAKE[BIT_TMR1_WK];
            watchdog_stop_disable_hi   <= RST_INT_WAKE[BIT_WD_STOP];
            global_int_scope           <= RST_EXT_WAKE[BIT_INT_SCOPE];
            measure_mode_select        <= RST_EXT_WAKE[BIT_MEAS];
        end else begin
            rail_peak_threshold_select <= bus_peak_nxt[BIT_PEAK_TH];
            second_timer_wake_enable   <= int_wake_nxt[BIT_TMR2_WK];
            first_timer_wake_enable    <= int_wake_nxt[BIT_TMR1_WK];
            watchdog_stop_disable_hi   <= int_wake_nxt[BIT_WD_STOP];
            global_int_scope           <= ext_wake_nxt[BIT_INT_SCOPE];
            measure_mode_select        <= ext_wake_nxt[BIT_MEAS];
        end
    end

    // measurement only takes the pins over in normal mode; the stored enables
    // are kept so that leaving normal mode restores wake use unchanged
    always_ff @(posedge clock) begin
        if (reset) begin
            input_one_wake_enable   <= RST_EXT_WAKE[BIT_IN1_WK];
            input_two_wake_enable   <= RST_EXT_WAKE[BIT_IN2_WK];
            input_three_wake_enable <= RST_EXT_WAKE[BIT_IN3_WK];
        end else begin
            input_one_wake_enable   <= ext_wake_nxt[BIT_IN1_WK]
                                       && !(ext_wake_nxt[BIT_MEAS] && mode_normal);
            input_two_wake_enable   <= ext_wake_nxt[BIT_IN2_WK]
                                       && !(ext_wake_nxt[BIT_MEAS] && mode_normal);
            input_three_wake_enable <= ext_wake_nxt[BIT_IN3_WK];
        end
    end

    // one-cycle request to the CAN mode logic to enter its wake-capable mode
    always_ff @(posedge clock) begin
        if (reset) begin
            can_wake_force <= 1'b0;
        end else begin
            can_wake_force <= failsafe_entry && !soft_reset;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_stop_peak_write;
        reg_wr_valid && reg_addr == ADDR_BUS_PEAK && mode_stop && !mode_init && !mode_normal
            && !soft_reset && !restart_entry;
    endsequence

    sequence s_quiet;
        !soft_reset && !restart_entry && !failsafe_entry;
    endsequence

    sequence s_peak_write;
        reg_wr_valid && reg_addr == ADDR_BUS_PEAK && !soft_reset && !restart_entry;
    endsequence

    sequence s_int_write;
        reg_wr_valid && reg_addr == ADDR_INT_WAKE;
    endsequence

    sequence s_ext_write;
        reg_wr_valid && reg_addr == ADDR_EXT_WAKE;
    endsequence

    a_stop_write_ignored: assert property (@(posedge clock) disable iff (reset)
        s_stop_peak_write |=> $stable(bus_peak_r) && $stable(rail_peak_threshold_select))
        else $error("threshold changed by a write in stop mode");

    a_peak_write_taken: assert property (@(posedge clock) disable iff (reset)
        reg_wr_valid && reg_addr == ADDR_BUS_PEAK && mode_normal && !soft_reset
            && !restart_entry
        |=> rail_peak_threshold_select == $past(reg_wr_data[BIT_PEAK_TH]))
        else $error("threshold write in normal mode not taken");

    a_peak_init_write: assert property (@(posedge clock) disable iff (reset)
        (s_peak_write and mode_init)
        |=> rail_peak_threshold_select == $past(reg_wr_data[BIT_PEAK_TH])
            && bus_peak_r == ($past(reg_wr_data) & MASK_BUS_PEAK))
        else $error("threshold write in init mode not taken");

    a_reserved_zero: assert property (@(posedge clock) disable iff (reset)
        reg_rd_ack && $past(reg_addr) == ADDR_INT_WAKE |-> (reg_rd_data & ~MASK_INT_WAKE) == 8'h00)
        else $error("reserved bits read non-zero");

    // the read mask alone would hide a stored reserved bit, so watch storage too
    a_reserved_stored: assert property (@(posedge clock) disable iff (reset)
        (bus_peak_r & ~MASK_BUS_PEAK) == 8'h00 && (int_wake_r & ~MASK_INT_WAKE) == 8'h00
            && (ext_wake_r & ~MASK_EXT_WAKE) == 8'h00)
        else $error("reserved bit held in storage");

    a_unmapped_reads: assert property (@(posedge clock) disable iff (reset)
        reg_rd_valid && reg_addr != ADDR_BUS_PEAK && reg_addr != ADDR_INT_WAKE
            && reg_addr != ADDR_EXT_WAKE
        |=> reg_rd_ack && reg_rd_data == 8'h00)
        else $error("unmapped read returned non-zero data");

    a_read_answered: assert property (@(posedge clock) disable iff (reset)
        reg_rd_valid |=> reg_rd_ack)
        else $error("read request left unanswered");

    a_timer_enables: assert property (@(posedge clock) disable iff (reset)
        (s_int_write and s_quiet)
        |=> second_timer_wake_enable == $past(reg_wr_data[BIT_TMR2_WK])
            && first_timer_wake_enable == $past(reg_wr_data[BIT_TMR1_WK]))
        else $error("timer wake enables do not follow the written value");

    a_wd_hw_update: assert property (@(posedge clock) disable iff (reset)
        wd_stop_hw_valid && !soft_reset && !restart_entry
        |=> watchdog_stop_disable_hi == $past(wd_stop_hw_value))
        else $error("hardware update of watchdog stop bit lost");

    a_ext_write_taken: assert property (@(posedge clock) disable iff (reset)
        (s_ext_write and s_quiet)
        |=> ext_wake_r == ($past(reg_wr_data) & MASK_EXT_WAKE)
            && global_int_scope == $past(reg_wr_data[BIT_INT_SCOPE])
            && measure_mode_select == $past(reg_wr_data[BIT_MEAS]))
        else $error("external wake write not taken");

    a_input_three: assert property (@(posedge clock) disable iff (reset)
        (s_ext_write and s_quiet)
        |=> input_three_wake_enable == $past(reg_wr_data[BIT_IN3_WK]))
        else $error("wake input three enable does not follow the write");

    a_meas_masking: assert property (@(posedge clock) disable iff (reset)
        measure_mode_select && $past(mode_normal) && $past(ext_wake_nxt[BIT_MEAS])
        |-> !input_one_wake_enable && !input_two_wake_enable)
        else $error("wake inputs one/two enabled during measurement");

    a_meas_outside_normal: assert property (@(posedge clock) disable iff (reset)
        measure_mode_select && !$past(mode_normal)
        |-> input_one_wake_enable == ext_wake_r[BIT_IN1_WK]
            && input_two_wake_enable == ext_wake_r[BIT_IN2_WK])
        else $error("wake inputs one/two masked outside normal mode");

    a_inputs_follow: assert property (@(posedge clock) disable iff (reset)
        !measure_mode_select
        |-> input_one_wake_enable == ext_wake_r[BIT_IN1_WK]
            && input_two_wake_enable == ext_wake_r[BIT_IN2_WK]
            && input_three_wake_enable == ext_wake_r[BIT_IN3_WK])
        else $error("wake input enables do not mirror the stored bits");

    // bits 7 and 5 of the external register survive fail-safe entry
    a_failsafe_pattern: assert property (@(posedge clock) disable iff (reset)
        failsafe_entry && !soft_reset
        |=> ext_wake_r == (($past(ext_wake_r) & KEEP_FS_EXT) | SET_FS_EXT) && can_wake_force
            && input_three_wake_enable && global_int_scope == $past(ext_wake_r[BIT_INT_SCOPE]))
        else $error("fail-safe pattern not applied");

    a_can_pulse_only: assert property (@(posedge clock) disable iff (reset)
        !failsafe_entry |=> !can_wake_force)
        else $error("CAN wake request without fail-safe entry");

    a_soft_reset_vals: assert property (@(posedge clock) disable iff (reset)
        soft_reset |=> bus_peak_r == RST_BUS_PEAK && int_wake_r == RST_INT_WAKE
            && ext_wake_r == RST_EXT_WAKE)
        else $error("soft reset values wrong");

    a_restart_pattern: assert property (@(posedge clock) disable iff (reset)
        restart_entry && !soft_reset && !failsafe_entry
        |=> bus_peak_r == ($past(bus_peak_r) & KEEP_RS_BUS)
            && ext_wake_r == ($past(ext_wake_r) & KEEP_RS_EXT)
            && int_wake_r == ($past(int_wake_r) & KEEP_RS_INT))
        else $error("restart pattern not applied");

endmodule

// File: dv/wbc_host.sv
// host model driving the register strobe port of the bank
module wbc_host
    import wbc_pkg::*;
(
    input  wire logic              clock,
    output logic                   wr_valid,
    output logic                   rd_valid,
    output logic [ADDR_W-1:0]      addr,
    output logic [DATA_W-1:0]      wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        wr_valid = 1'b0;
        rd_valid = 1'b0;
        addr     = '0;
        wdata    = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // released lines get inverted so a late sample never sees stale data
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock);
        wr_valid <= 1'b1;
        addr     <= a;
        wdata    <= d;
        @(posedge clock);
        wr_valid <= 1'b0;
        addr     <= ~a;
        wdata    <= ~d;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge clock);
        rd_valid <= 1'b1;
        addr     <= a;
        @(posedge clock);
        rd_valid <= 1'b0;
        addr     <= ~a;
    endtask
endmodule

// File: dv/wake_and_bus_ctrl_regs_tb.sv
// self-checking bench for the wake and bus control register bank
module wake_and_bus_ctrl_regs_tb;
    import wbc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic              clock = 1'b0;
    logic              reset = 1'b1;
    logic [2:0]        md = 3'b010;
    logic [3:0]        ev = 4'h0;
    logic              hw_val = 1'b0;
    logic              wr_valid;
    logic              rd_valid;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rd_data;
    logic              rd_ack;
    logic              can_f;
    logic [8:0]        flds;
    logic [7:0]        exp_q[$];
    logic [7:0]        v;
    int                bad_count = 0;
    int                tests_run = 0;

    always #5 clock = ~clock;

    wbc_host host (.clock(clock), .wr_valid(wr_valid), .rd_valid(rd_valid),
                   .addr(addr), .wdata(wdata));

    // md: init, normal, stop; ev: soft reset, restart, fail-safe, hw watchdog write
    wbc_regs dut (.clock(clock), .reset(reset), .reg_wr_valid(wr_valid),
        .reg_rd_valid(rd_valid), .reg_addr(addr), .reg_wr_data(wdata),
        .mode_init(md[0]), .mode_normal(md[1]), .mode_stop(md[2]),
        .soft_reset(ev[0]), .restart_entry(ev[1]), .failsafe_entry(ev[2]),
        .wd_stop_hw_valid(ev[3]), .wd_stop_hw_value(hw_val),
        .reg_rd_data(rd_data), .reg_rd_ack(rd_ack),
        .rail_peak_threshold_select(flds[8]), .second_timer_wake_enable(flds[7]),
        .first_timer_wake_enable(flds[6]), .watchdog_stop_disable_hi(flds[5]),
        .global_int_scope(flds[4]), .measure_mode_select(flds[3]),
        .input_three_wake_enable(flds[2]), .input_two_wake_enable(flds[1]),
        .input_one_wake_enable(flds[0]), .can_wake_force(can_f));

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.rd(a);
    endtask

    task automatic rd3(input logic [7:0] e5, input logic [7:0] e6, input logic [7:0] e7);
        rd(ADDR_BUS_PEAK, e5);
        rd(ADDR_INT_WAKE, e6);
        rd(ADDR_EXT_WAKE, e7);
    endtask

    task automatic pulse(input int i);
        @(posedge clock);
        ev[i] <= 1'b1;
        @(posedge clock);
        ev[i] <= 1'b0;
        #1;
    endtask

    // oldest expectation is matched against each read answer
    always @(posedge clock) begin
        if (rd_ack === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("unexpected rd_ack", 9'h000, 9'h1ff);
            end else begin
                chk("reg_rd_data", {1'b0, exp_q.pop_front()}, {1'b0, rd_data});
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h14a7eb59));
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        #1 chk("fields after reset", 9'h007, flds);
        rd3(8'h00, 8'h00, 8'h07);
        host.wr(ADDR_BUS_PEAK, 8'hff);
        host.wr(ADDR_INT_WAKE, 8'hff);
        host.wr(ADDR_EXT_WAKE, 8'hff);
        #1 chk("fields normal", 9'h1fc, flds);
        rd3(8'h20, 8'hc4, 8'ha7);
        @(posedge clock) md <= 3'b001;
        @(posedge clock);
        #1 chk("fields init", 9'h1ff, flds);
        @(posedge clock) md <= 3'b100;
        host.wr(ADDR_BUS_PEAK, 8'h00);
        rd(ADDR_BUS_PEAK, 8'h20);
        @(posedge clock) md <= 3'b001;
        host.wr(ADDR_BUS_PEAK, 8'h00);
        rd(ADDR_BUS_PEAK, 8'h00);
        @(posedge clock) md <= 3'b010;
        host.wr(ADDR_BUS_PEAK, 8'h20);
        for (int k = 0; k < 8; k++) begin
            v = 8'($urandom);
            host.wr(ADDR_INT_WAKE, v);
            host.wr(ADDR_EXT_WAKE, v);
            host.wr(7'h10, v);
            #1 chk("fields", {1'b1, v[7], v[6], v[2], v[7], v[5], v[2],
                v[1] & ~v[5], v[0] & ~v[5]}, flds);
            rd(ADDR_INT_WAKE, v & 8'hc4);
            rd(ADDR_EXT_WAKE, v & 8'ha7);
            rd(7'h10, 8'h00);
        end
        host.wr(ADDR_INT_WAKE, 8'hff);
        host.wr(ADDR_EXT_WAKE, 8'ha5);
        pulse(1);
        rd3(8'h20, 8'hc0, 8'ha5);
        pulse(2);
        chk("can_wake_force", 9'h001, {8'h00, can_f});
        @(posedge clock);
        #1 chk("can_wake_force end", 9'h000, {8'h00, can_f});
        rd3(8'h20, 8'hc0, 8'ha7);
        hw_val <= 1'b1;
        pulse(3);
        rd(ADDR_INT_WAKE, 8'hc4);
        pulse(0);
        rd3(8'h00, 8'h00, 8'h07);
        repeat (3) @(posedge clock);
        chk("pending reads", 9'h000, 9'(exp_q.size()));
        give_verdict();
    end

    // the whole sequence needs well under a thousand cycles
    initial begin
        #100000;
        bad_count++;
        give_verdict();
    end
endmodule
